// file: hw/ppx_pkg.sv
package ppx_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_PINS = 16;
	localparam int NUM_FUNCS = 15;
	localparam int PIN_W = 4;
	// ----------------------------------------------------------------
	// Function slots, in rank order after the fixed UART pair
	// ----------------------------------------------------------------
	localparam int FN_SPI_SCK = 0;
	localparam int FN_SPI_MISO = 1;
	localparam int FN_SPI_MOSI = 2;
	localparam int FN_SPI_NSS = 3;
	localparam int FN_SMB_SDA = 4;
	localparam int FN_SMB_SCL = 5;
	localparam int FN_CMP_SYNC = 6;
	localparam int FN_CMP_ASYNC = 7;
	localparam int FN_SYSCLK = 8;
	localparam int FN_PCA0 = 9;
	localparam int FN_PCA1 = 10;
	localparam int FN_PCA2 = 11;
	localparam int FN_ECI = 12;
	localparam int FN_T0 = 13;
	localparam int FN_T1 = 14;
	// Fixed pins of the primary UART
	localparam logic [PIN_W-1:0] UART_TX_PIN = 4'h4;
	localparam logic [PIN_W-1:0] UART_RX_PIN = 4'h5;
	// ----------------------------------------------------------------
	// routing_enables_a fields
	// ----------------------------------------------------------------
	localparam int ENA_UART = 0;
	localparam int ENA_SPI = 1;
	localparam int ENA_SMB = 2;
	localparam int ENA_SYSCLK = 3;
	localparam int ENA_CMP = 4;
	localparam int ENA_CMP_ASYNC = 5;
	// routing_enables_b fields
	localparam int ENB_PCA_LSB = 0;
	localparam int ENB_ECI = 3;
	localparam int ENB_T0 = 4;
	localparam int ENB_T1 = 5;
	// routing_enables_c fields
	localparam int ENC_PULLUP_DIS = 7;
	localparam int ENC_GLOBAL = 6;
	// Slave-select mode value that means 3-wire
	localparam logic [1:0] NSS_MODE_3WIRE = 2'h0;
	localparam logic [7:0] ENABLES_RESET = 8'h00;
	localparam logic [NUM_PINS-1:0] SKIP_RESET = 16'h0000;
	localparam logic [NUM_PINS-1:0] MODE_RESET = 16'h0000;
	localparam logic [NUM_PINS-1:0] DIGITAL_RESET = 16'hFFFF;
	localparam logic [NUM_PINS-1:0] LATCH_RESET = 16'hFFFF;
	localparam logic [7:0] MISC_RESET = 8'h00;
	// ----------------------------------------------------------------
	// Software port offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] A_ENA = 4'h0;
	localparam logic [3:0] A_ENB = 4'h1;
	localparam logic [3:0] A_ENC = 4'h2;
	localparam logic [3:0] A_SKIP = 4'h3;
	localparam logic [3:0] A_MODE = 4'h4;
	localparam logic [3:0] A_DIG = 4'h5;
	localparam logic [3:0] A_LATCH = 4'h6;
	localparam logic [3:0] A_MISC = 4'h7;
	localparam logic [3:0] A_READ = 4'h8;
endpackage : ppx_pkg

// file: hw/ppx_if.sv
`timescale 1ns/1ps
interface ppx_if;
	import ppx_pkg::*;
	// Peripheral side outputs and enables, by function slot
	logic [NUM_FUNCS-1:0] fn_out;
	logic [NUM_FUNCS-1:0] fn_oe;
	logic [NUM_FUNCS-1:0] fn_in;
	logic uart_tx;
	logic uart_rx;
	// Configuration seen by the crossbar
	logic [7:0] routing_enables_a;
	logic [7:0] routing_enables_b;
	logic [7:0] routing_enables_c;
	logic [NUM_PINS-1:0] pin_skip_mask;
	logic [NUM_PINS-1:0] output_drive_mode;
	logic [NUM_PINS-1:0] input_analog_digital_select;
	logic [NUM_PINS-1:0] gpio_latch;
	logic [1:0] slave_select_mode_bits;
	logic [2:0] ext_int0_sel;
	logic [2:0] ext_int1_sel;
	// Results back to the peripherals
	logic [NUM_PINS-1:0] port_read;
	logic [NUM_PINS-1:0] event_ok;
	logic ext_int0;
	logic ext_int1;
	modport xbar (
		input fn_out, fn_oe, uart_tx, routing_enables_a, routing_enables_b,
		input routing_enables_c, pin_skip_mask, output_drive_mode,
		input input_analog_digital_select, gpio_latch, slave_select_mode_bits,
		input ext_int0_sel, ext_int1_sel,
		output fn_in, uart_rx, port_read, event_ok, ext_int0, ext_int1
	);
	modport periph (
		output fn_out, fn_oe, uart_tx, routing_enables_a, routing_enables_b,
		output routing_enables_c, pin_skip_mask, output_drive_mode,
		output input_analog_digital_select, gpio_latch, slave_select_mode_bits,
		output ext_int0_sel, ext_int1_sel,
		input fn_in, uart_rx, port_read, event_ok, ext_int0, ext_int1
	);
endinterface : ppx_if

// file: hw/ppx_crossbar.sv
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module ppx_crossbar
	import ppx_pkg::*;
#(
	parameter int PINS = NUM_PINS
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Peripheral side
	ppx_if.xbar bus,
	// Pads
	input wire logic [NUM_PINS-1:0] pad_i,
	output logic [NUM_PINS-1:0] pad_o,
	output logic [NUM_PINS-1:0] pad_oe_o,
	output logic [NUM_PINS-1:0] pad_pullup_o,
	output logic [NUM_PINS-1:0] pad_rx_en_o
);
	import ppx_pkg::*;

	// The pin map and pad ports are sized by the package; other counts are refused
	if (PINS != NUM_PINS) begin : g_pins_check
		$error("ppx_crossbar supports only NUM_PINS pins");
	end

	// ----------------------------------------------------------------
	// Requests
	// ----------------------------------------------------------------
	logic [NUM_FUNCS-1:0] req;
	logic uart_en;
	logic [2:0] pca_code;
	always_comb begin
		uart_en = bus.routing_enables_a[ENA_UART];
		pca_code = bus.routing_enables_b[ENB_PCA_LSB +: 3];
		req = '0;
		req[FN_SPI_SCK] = bus.routing_enables_a[ENA_SPI];
		req[FN_SPI_MISO] = bus.routing_enables_a[ENA_SPI];
		req[FN_SPI_MOSI] = bus.routing_enables_a[ENA_SPI];
		// 3-wire mode leaves slave-select off the pins
		req[FN_SPI_NSS] = bus.routing_enables_a[ENA_SPI] &&
			(bus.slave_select_mode_bits != NSS_MODE_3WIRE);
		req[FN_SMB_SDA] = bus.routing_enables_a[ENA_SMB];
		req[FN_SMB_SCL] = bus.routing_enables_a[ENA_SMB];
		req[FN_CMP_SYNC] = bus.routing_enables_a[ENA_CMP];
		req[FN_CMP_ASYNC] = bus.routing_enables_a[ENA_CMP_ASYNC];
		req[FN_SYSCLK] = bus.routing_enables_a[ENA_SYSCLK];
		// Reserved codes route nothing
		req[FN_PCA0] = (pca_code >= 3'h1) && (pca_code <= 3'h3);
		req[FN_PCA1] = (pca_code >= 3'h2) && (pca_code <= 3'h3);
		req[FN_PCA2] = (pca_code == 3'h3);
		req[FN_ECI] = bus.routing_enables_b[ENB_ECI];
		req[FN_T0] = bus.routing_enables_b[ENB_T0];
		req[FN_T1] = bus.routing_enables_b[ENB_T1];
	end

	// ----------------------------------------------------------------
	// Priority allocation
	// ----------------------------------------------------------------
	// Slot index order is rank order; a linear scan keeps it obvious
	logic [NUM_PINS-1:0] taken;
	logic [NUM_PINS-1:0] owned_d [NUM_FUNCS];
	always_comb begin
		taken = bus.pin_skip_mask;
		if (uart_en) begin
			taken[UART_TX_PIN] = 1'b1;
			taken[UART_RX_PIN] = 1'b1;
		end
		// A function that finds no free pin stays unrouted; nothing flags it
		for (int f = 0; f < NUM_FUNCS; f++) begin
			owned_d[f] = '0;
			if (req[f]) begin
				for (int p = NUM_PINS - 1; p >= 0; p--) begin
					if (!taken[p]) begin
						owned_d[f] = '0;
						owned_d[f][p] = 1'b1;
					end
				end
				taken = taken | owned_d[f];
			end
		end
	end

	// ----------------------------------------------------------------
	// Registered map
	// ----------------------------------------------------------------
	// Registered map so the pads switch on a clock edge
	logic [NUM_PINS-1:0] owned_q [NUM_FUNCS];
	logic uart_en_q;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int f = 0; f < NUM_FUNCS; f++) begin
				owned_q[f] <= '0;
			end
			uart_en_q <= 1'b0;
		end else begin
			for (int f = 0; f < NUM_FUNCS; f++) begin
				owned_q[f] <= owned_d[f];
			end
			uart_en_q <= uart_en;
		end
	end

	// ----------------------------------------------------------------
	// Pad drive
	// ----------------------------------------------------------------
	logic xbar_on;
	logic [NUM_PINS-1:0] smb_pins;
	logic [NUM_PINS-1:0] drv_val;
	logic [NUM_PINS-1:0] drv_en;
	always_comb begin
		xbar_on = bus.routing_enables_c[ENC_GLOBAL];
		smb_pins = owned_q[FN_SMB_SDA] | owned_q[FN_SMB_SCL];
		for (int p = 0; p < NUM_PINS; p++) begin
			// Unrouted pins fall back to the port latch
			drv_val[p] = bus.gpio_latch[p];
			drv_en[p] = 1'b1;
			for (int f = 0; f < NUM_FUNCS; f++) begin
				if (owned_q[f][p]) begin
					drv_val[p] = bus.fn_out[f];
					drv_en[p] = bus.fn_oe[f];
				end
			end
			if (uart_en_q && (p == int'(UART_TX_PIN))) begin
				drv_val[p] = bus.uart_tx;
			end
			if (uart_en_q && (p == int'(UART_RX_PIN))) begin
				drv_en[p] = 1'b0;
			end
		end
	end

	always_comb begin
		for (int p = 0; p < NUM_PINS; p++) begin
			pad_o[p] = 1'b0;
			pad_oe_o[p] = 1'b0;
			// Open-drain: pull low only, release for a one
			if (xbar_on && drv_en[p] && bus.input_analog_digital_select[p]) begin
				if (bus.output_drive_mode[p] && !smb_pins[p]) begin
					pad_oe_o[p] = 1'b1;
					pad_o[p] = drv_val[p];
				end else begin
					pad_oe_o[p] = !drv_val[p];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Pad cell controls
	// ----------------------------------------------------------------
	// Analog pins lose receiver and pull-up
	assign pad_rx_en_o = bus.input_analog_digital_select;
	assign pad_pullup_o = bus.input_analog_digital_select & ~pad_oe_o &
		{NUM_PINS{!bus.routing_enables_c[ENC_PULLUP_DIS]}};

	// ----------------------------------------------------------------
	// Input path
	// ----------------------------------------------------------------
	// Pads are asynchronous to mclk_i, so only the second flop is read
	logic [NUM_PINS-1:0] pad_s1_q;
	logic [NUM_PINS-1:0] pad_s2_q;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pad_s1_q <= '0;
			pad_s2_q <= '0;
		end else begin
			pad_s1_q <= pad_i;
			pad_s2_q <= pad_s1_q;
		end
	end

	logic [NUM_PINS-1:0] rd;
	assign rd = pad_s2_q & bus.input_analog_digital_select;

	// Interrupt lines are levels; the consumer does its own edge detection
	logic [NUM_PINS-1:0] read_q;
	logic [NUM_FUNCS-1:0] fn_in_q;
	logic uart_rx_q;
	logic int0_q;
	logic int1_q;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			read_q <= '0;
			fn_in_q <= '0;
			uart_rx_q <= 1'b1;
			int0_q <= 1'b0;
			int1_q <= 1'b0;
		end else begin
			read_q <= rd;
			for (int f = 0; f < NUM_FUNCS; f++) begin
				fn_in_q[f] <= |(owned_q[f] & rd);
			end
			uart_rx_q <= uart_en_q ? rd[UART_RX_PIN] : 1'b1;
			// Interrupts pick from port 0 only
			int0_q <= rd[{1'b0, bus.ext_int0_sel}];
			int1_q <= rd[{1'b0, bus.ext_int1_sel}];
		end
	end

	// ----------------------------------------------------------------
	// Results to peripherals
	// ----------------------------------------------------------------
	assign bus.port_read = read_q;
	assign bus.fn_in = fn_in_q;
	assign bus.uart_rx = uart_rx_q;
	assign bus.ext_int0 = int0_q;
	assign bus.ext_int1 = int1_q;
	assign bus.event_ok = bus.input_analog_digital_select;
endmodule : ppx_crossbar

// file: hw/ppx_periph_cfg.sv
`timescale 1ns/1ps
module ppx_periph_cfg
	import ppx_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Crossbar side
	ppx_if.periph bus,
	// Software port
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// Peripheral signals
	input wire logic [NUM_FUNCS-1:0] fn_out_i,
	input wire logic [NUM_FUNCS-1:0] fn_oe_i,
	input wire logic uart_tx_i,
	output logic [NUM_FUNCS-1:0] fn_in_o,
	output logic uart_rx_o,
	output logic ext_int0_o,
	output logic ext_int1_o
);
	import ppx_pkg::*;

	logic [7:0] ena_q, enb_q, enc_q;
	logic [NUM_PINS-1:0] skip_q, mode_q, dig_q, latch_q;
	logic [7:0] misc_q;
	logic [15:0] rdata_q;

	// Software owns skip bits for analog, dedicated and unbonded pins
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ena_q <= ENABLES_RESET;
			enb_q <= ENABLES_RESET;
			enc_q <= ENABLES_RESET;
			skip_q <= SKIP_RESET;
			mode_q <= MODE_RESET;
			dig_q <= DIGITAL_RESET;
			latch_q <= LATCH_RESET;
			misc_q <= MISC_RESET;
		end else if (wr_i) begin
			case (addr_i)
				A_ENA: ena_q <= {2'h0, wdata_i[5:0]};
				A_ENB: enb_q <= {2'h0, wdata_i[5:0]};
				A_ENC: enc_q <= {wdata_i[7:6], 6'h00};
				A_SKIP: skip_q <= wdata_i;
				A_MODE: mode_q <= wdata_i;
				A_DIG: dig_q <= wdata_i;
				A_LATCH: latch_q <= wdata_i;
				A_MISC: misc_q <= wdata_i[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= 16'h0000;
		end else if (rd_i) begin
			case (addr_i)
				A_ENA: rdata_q <= {8'h00, ena_q};
				A_ENB: rdata_q <= {8'h00, enb_q};
				A_ENC: rdata_q <= {8'h00, enc_q};
				A_SKIP: rdata_q <= skip_q;
				A_MODE: rdata_q <= mode_q;
				A_DIG: rdata_q <= dig_q;
				A_LATCH: rdata_q <= latch_q;
				A_MISC: rdata_q <= {8'h00, misc_q};
				A_READ: rdata_q <= bus.port_read;
				default: rdata_q <= 16'h0000;
			endcase
		end else begin
			rdata_q <= 16'h0000;
		end
	end
	assign rdata_o = rdata_q;

	assign bus.routing_enables_a = ena_q;
	assign bus.routing_enables_b = enb_q;
	assign bus.routing_enables_c = enc_q;
	assign bus.pin_skip_mask = skip_q;
	assign bus.output_drive_mode = mode_q;
	assign bus.input_analog_digital_select = dig_q;
	assign bus.gpio_latch = latch_q;
	assign bus.slave_select_mode_bits = misc_q[1:0];
	assign bus.ext_int0_sel = misc_q[4:2];
	assign bus.ext_int1_sel = misc_q[7:5];
	assign bus.fn_out = fn_out_i;
	assign bus.fn_oe = fn_oe_i;
	assign bus.uart_tx = uart_tx_i;
	assign fn_in_o = bus.fn_in;
	assign uart_rx_o = bus.uart_rx;
	assign ext_int0_o = bus.ext_int0;
	assign ext_int1_o = bus.ext_int1;
endmodule : ppx_periph_cfg

// file: testbench/ppx_chk.sv
`timescale 1ns/1ps
module ppx_chk
	import ppx_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Interface signals
	input wire logic [NUM_FUNCS-1:0] fn_out,
	input wire logic [NUM_FUNCS-1:0] fn_oe,
	input wire logic uart_tx,
	input wire logic [7:0] routing_enables_a,
	input wire logic [7:0] routing_enables_b,
	input wire logic [7:0] routing_enables_c,
	input wire logic [NUM_PINS-1:0] pin_skip_mask,
	input wire logic [NUM_PINS-1:0] output_drive_mode,
	input wire logic [NUM_PINS-1:0] input_analog_digital_select,
	input wire logic [NUM_PINS-1:0] gpio_latch,
	input wire logic [1:0] slave_select_mode_bits,
	input wire logic [NUM_PINS-1:0] port_read,
	input wire logic [NUM_PINS-1:0] event_ok,
	// Pads of the device end
	input wire logic [NUM_PINS-1:0] pad_o,
	input wire logic [NUM_PINS-1:0] pad_oe_o
);
	logic [89:0] cfg_d;
	logic [89:0] cfg_q;
	logic vld_q;
	logic steady;
	logic on;
	logic spi_only;
	// Map is registered, so judge pads only once config held over one edge
	assign cfg_d = {routing_enables_a, routing_enables_b, routing_enables_c, pin_skip_mask,
		output_drive_mode, input_analog_digital_select, gpio_latch, slave_select_mode_bits};
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_q <= '0;
			vld_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			vld_q <= 1'b1;
		end
	end
	assign steady = vld_q && (cfg_d == cfg_q);
	assign on = steady && routing_enables_c[ENC_GLOBAL] && fn_oe == '1 && output_drive_mode == '1
		&& input_analog_digital_select == '1;
	assign spi_only = on && pin_skip_mask == '0 && routing_enables_a == 8'h02
		&& routing_enables_b == 8'h00;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	a_drivers_off_disabled: assert property (
		steady && !routing_enables_c[ENC_GLOBAL] |-> pad_oe_o == '0)
		else $error("pad driven while routing disabled");
	a_spi_low_pins: assert property (
		spi_only |-> pad_o[2:0] == fn_out[2:0] && pad_oe_o[2:0] == 3'h7)
		else $error("spi not on lowest pins");
	a_nss_four_wire: assert property (
		spi_only && slave_select_mode_bits != NSS_MODE_3WIRE |-> pad_o[3] == fn_out[FN_SPI_NSS])
		else $error("slave select missing in 4-wire");
	a_gpio_after_spi: assert property (
		spi_only && slave_select_mode_bits == NSS_MODE_3WIRE |-> pad_o[3] == gpio_latch[3])
		else $error("pin after 3-wire spi not gpio");
	a_uart_tx_fixed: assert property (
		on && routing_enables_a[ENA_UART] |-> pad_oe_o[4] && pad_o[4] == uart_tx)
		else $error("uart transmit not on pin 4");
	a_uart_rx_released: assert property (
		on && routing_enables_a[ENA_UART] |-> !pad_oe_o[5])
		else $error("uart receive pin driven");
	a_smb_open_drain: assert property (
		on && pin_skip_mask == '0 && routing_enables_a == 8'h04 && routing_enables_b == 8'h00
		|-> pad_oe_o[1:0] == ~fn_out[FN_SMB_SCL:FN_SMB_SDA])
		else $error("smbus pins not open-drain");
	a_skip_passover: assert property (
		on && pin_skip_mask == 16'h0001 && routing_enables_a == 8'h02
		&& routing_enables_b == 8'h00 |-> pad_o[3:1] == fn_out[2:0])
		else $error("skipped pin not passed over");
	a_analog_reads_zero: assert property (
		(!input_analog_digital_select[0]) [*4] |-> !port_read[0])
		else $error("analog pin reads one");
	a_event_analog_off: assert property (
		(event_ok & ~input_analog_digital_select) == '0)
		else $error("event capture enabled on analog pin");
endmodule : ppx_chk

// file: testbench/ppx_crossbar_tb.sv
`timescale 1ns/1ps
module ppx_crossbar_tb;
	import ppx_pkg::*;
	logic mclk_i;
	logic rst_n_i;
	logic [3:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic wr;
	logic rd;
	logic [NUM_FUNCS-1:0] fn_out_i;
	logic [NUM_FUNCS-1:0] fn_oe_i;
	logic uart_tx_i;
	logic uart_rx;
	logic [NUM_PINS-1:0] pad_i;
	logic [NUM_PINS-1:0] pad_o;
	logic [NUM_PINS-1:0] pad_oe;
	logic [NUM_PINS-1:0] pad_pu;
	logic [NUM_PINS-1:0] pad_rx;
	logic [NUM_FUNCS-1:0] fn_in;
	logic int0;
	logic int1;
	int slot [7] = '{FN_CMP_SYNC, FN_CMP_ASYNC, FN_SYSCLK, FN_PCA0, FN_ECI, FN_T0, FN_T1};
	logic [15:0] d;
	logic [14:0] vs [2] = '{15'h2AAA, 15'h5555};
	int err_total;
	int samples_checked;
	ppx_if bus_if();
	ppx_crossbar ppx_crossbar_i(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(bus_if), .pad_i(pad_i),
		.pad_o(pad_o), .pad_oe_o(pad_oe), .pad_pullup_o(pad_pu), .pad_rx_en_o(pad_rx));
	ppx_periph_cfg ppx_periph_cfg_i(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(bus_if),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.fn_out_i(fn_out_i), .fn_oe_i(fn_oe_i), .uart_tx_i(uart_tx_i), .fn_in_o(fn_in),
		.uart_rx_o(uart_rx), .ext_int0_o(int0), .ext_int1_o(int1));
	ppx_chk ppx_chk_i(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .fn_out(bus_if.fn_out),
		.fn_oe(bus_if.fn_oe), .uart_tx(bus_if.uart_tx),
		.routing_enables_a(bus_if.routing_enables_a), .routing_enables_b(bus_if.routing_enables_b),
		.routing_enables_c(bus_if.routing_enables_c), .pin_skip_mask(bus_if.pin_skip_mask),
		.output_drive_mode(bus_if.output_drive_mode), .gpio_latch(bus_if.gpio_latch),
		.input_analog_digital_select(bus_if.input_analog_digital_select),
		.slave_select_mode_bits(bus_if.slave_select_mode_bits), .port_read(bus_if.port_read),
		.event_ok(bus_if.event_ok),
		.pad_o(pad_o), .pad_oe_o(pad_oe));
	// ----
	// Bus cycles and compare
	// ----
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
		@(posedge mclk_i);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk_i);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
		@(posedge mclk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_i);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	// Map follows config one edge late; pads input path is deeper still
	task automatic settle(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : settle
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic results();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results
	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		check(pad_oe, 16'h0000);
		rd_reg(A_DIG, d);
		check(d, DIGITAL_RESET);
		check({15'h0, uart_rx}, 16'h0001);
	endtask : t_reset
	task automatic t_enable();
		wr_reg(A_MODE, 16'hFFFF);
		wr_reg(A_LATCH, 16'h0000);
		wr_reg(A_ENA, 16'h0002);
		settle(3);
		check(pad_oe, 16'h0000);
		wr_reg(A_ENC, 16'h0040);
		settle(3);
		check({13'h0, pad_o[2:0]}, {13'h0, fn_out_i[2:0]});
		wr_reg(A_MISC, 16'h0001);
		settle(3);
		check({15'h0, pad_o[3]}, {15'h0, fn_out_i[FN_SPI_NSS]});
		wr_reg(A_MISC, 16'h0000);
		wr_reg(A_SKIP, 16'h0001);
		settle(3);
		check({13'h0, pad_o[3:1]}, {13'h0, fn_out_i[2:0]});
		wr_reg(A_SKIP, 16'h0000);
	endtask : t_enable
	task automatic t_spi_wire();
		for (int m = 0; m < 2; m++) begin
			wr_reg(A_MISC, 16'(m));
			wr_reg(A_ENA, 16'h0007);
			settle(4);
			check({11'h0, pad_oe[7:3]}, m ? 16'h000B : 16'h0013);
		end
		wr_reg(A_MISC, 16'h0000);
	endtask : t_spi_wire
	task automatic t_skip();
		wr_reg(A_SKIP, 16'h0009);
		wr_reg(A_ENA, 16'h0003);
		for (int i = 0; i < 2; i++) begin
			@(posedge mclk_i);
			fn_out_i <= vs[i];
			settle(4);
			check({12'h0, pad_o[6], pad_o[2:0]}, {12'h0, vs[i][2:0], 1'b0});
		end
		@(posedge mclk_i);
		pad_i <= 16'hFFFB;
		settle(4);
		check({1'b0, fn_in}, 16'h0005);
		@(posedge mclk_i);
		pad_i <= 16'hFFFF;
		wr_reg(A_SKIP, 16'h0000);
	endtask : t_skip
	task automatic t_smb();
		wr_reg(A_ENA, 16'h0004);
		for (int i = 0; i < 2; i++) begin
			@(posedge mclk_i);
			fn_out_i <= vs[i];
			settle(4);
			check({14'h0, pad_oe[1:0]}, {14'h0, ~vs[i][5:4]});
		end
	endtask : t_smb
	task automatic t_uart();
		wr_reg(A_ENA, 16'h0001);
		for (int b = 0; b < 2; b++) begin
			@(posedge mclk_i);
			uart_tx_i <= 1'(b);
			pad_i[5] <= 1'(b);
			settle(7);
			check({14'h0, pad_o[4], uart_rx}, {14'h0, 1'(b), 1'(b)});
		end
	endtask : t_uart
	task automatic t_pca();
		int n;
		wr_reg(A_ENA, 16'h0000);
		fn_out_i <= '1;
		for (int c = 0; c < 8; c++) begin
			wr_reg(A_ENB, 16'(c));
			settle(3);
			n = (c < 4) ? c : 0;
			check({12'h0, pad_o[3:0]}, 16'((1 << n) - 1));
		end
	endtask : t_pca
	// One function driven high at a time shows which pin each rank lands on
	task automatic t_rank();
		wr_reg(A_ENB, 16'h0039);
		wr_reg(A_ENA, 16'h0038);
		for (int i = 0; i < 7; i++) begin
			@(posedge mclk_i);
			fn_out_i <= 15'(1 << slot[i]);
			settle(4);
			check(pad_o, 16'(1 << i));
		end
		wr_reg(A_ENA, 16'h0000);
		wr_reg(A_ENB, 16'h0000);
	endtask : t_rank
	task automatic t_analog();
		wr_reg(A_SKIP, 16'h1001);
		wr_reg(A_MODE, 16'h0000);
		wr_reg(A_LATCH, 16'hFFFF);
		wr_reg(A_DIG, 16'hFFFE);
		settle(6);
		rd_reg(A_READ, d);
		check(d, 16'hFFFE);
		check(pad_rx, 16'hFFFE);
		check(pad_pu, 16'hFFFE);
		wr_reg(A_DIG, 16'hFFFF);
	endtask : t_analog
	task automatic t_ext_int();
		wr_reg(A_MISC, 16'h00AC);
		@(posedge mclk_i);
		pad_i <= 16'h0020;
		settle(4);
		check({14'h0, int1, int0}, 16'h0002);
		@(posedge mclk_i);
		pad_i <= 16'h0008;
		settle(4);
		check({14'h0, int1, int0}, 16'h0001);
		wr_reg(A_DIG, 16'hFFF7);
		settle(3);
		check({14'h0, int1, int0}, 16'h0000);
	endtask : t_ext_int
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	initial begin
		#200000;
		err_total++;
		results();
	end
	initial begin
		rst_n_i = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		fn_out_i = 15'h2AAA;
		fn_oe_i = '1;
		uart_tx_i = 1'b1;
		pad_i = 16'hFFFF;
		err_total = 0;
		samples_checked = 0;
		repeat (12) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		settle(1);
		t_reset();
		t_enable();
		t_spi_wire();
		t_skip();
		t_smb();
		t_uart();
		t_pca();
		t_rank();
		t_analog();
		t_ext_int();
		results();
	end
endmodule : ppx_crossbar_tb
